// ===== hdl/cycle_interval_timer.sv
`timescale 1ns/100ps

module cycle_interval_timer #(
  parameter int unsigned PRESC_NORM = 80,
  parameter int unsigned PRESC_STR  = 4000,
  parameter int unsigned IVL_W      = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic             stretch_i,
  input  wire logic [IVL_W-1:0] interval_i,
  output logic                  expired_o
);

  localparam int unsigned PMAX = (PRESC_STR > PRESC_NORM) ? PRESC_STR
                                                          : PRESC_NORM;
  localparam int unsigned PW   = (PMAX > 1) ? $clog2(PMAX) : 1;

  if (PRESC_NORM < 1 || PRESC_STR < 1 || IVL_W < 1) begin : g_chk
    $error("Prescaler values and interval width must be at least one");
  end

  logic [PW-1:0]    presc_q;
  logic [IVL_W-1:0] left_q;

  // Step enable: one pulse per interval unit, restarted on load
  wire [PW-1:0] presc_top = stretch_i ? PW'(PRESC_STR - 1)
                                      : PW'(PRESC_NORM - 1);
  wire          tick      = (left_q != '0) && (presc_q == presc_top);

  // Expiry shows in the cycle of the last step, so intervals are exact
  assign expired_o = (left_q == '0) | ((left_q == IVL_W'(1)) & tick);

  // Prescaler and step counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_q <= '0;
      left_q  <= '0;
    end else if (load_i) begin
      presc_q <= '0;
      left_q  <= interval_i;
    end else if (left_q != '0) begin
      presc_q <= tick ? '0 : presc_q + 1'b1;
      left_q  <= tick ? left_q - 1'b1 : left_q;
    end
  end

endmodule : cycle_interval_timer

// ===== hdl/strain_cycle_timing_averaging.sv
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`include "strain_regs.svh"

module strain_cycle_timing_averaging #(
  parameter int unsigned TIME_W = 18,
  parameter int unsigned ACC_W  = 32
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        comp_i,
  output logic             discharge_o,
  output logic [2:0]       port_sel_o,
  output logic             calib_o,
  output logic             busy_o,
  output logic             irq_o
);

  localparam int unsigned IVL_W      = strain_pkg::IVL_W;
  localparam int unsigned AVG_W      = strain_pkg::AVG_W;
  localparam int unsigned PRESC_NORM = `STEP_NORM_NS / `CLK_PERIOD_NS;
  localparam int unsigned PRESC_STR  = `STEP_STR_NS / `CLK_PERIOD_NS;
  localparam int unsigned EXTRA      = `EXTRA_CYCLES;
  localparam logic [TIME_W-1:0]       TM_MAX = '1;
  localparam logic signed [ACC_W-1:0] RMAX   = ACC_W'(`RESULT_MAX);
  localparam logic signed [ACC_W-1:0] RMIN   = -RMAX;

  if (TIME_W < 17 || ACC_W < TIME_W + AVG_W + 4 || ACC_W > 64 ||
      EXTRA < 1 || EXTRA > 7) begin : g_chk
    $error("Time or accumulator width too small, or extra count invalid");
  end

  strain_pkg::seq_state_t st_q, st_d;
  strain_pkg::seq_cfg_t   seq_q, cfg_live;

  logic [31:0]       cfg2_q, cfg3_q, rdata_q, rmux;
  logic              wait_q, run_q, disch_q, busy_q, calib_q, irq_q;
  logic [1:0]        sts_q, mask_q;
  logic [23:0]       result_q;
  logic [2:0]        cyc_q, xcnt_q;
  logic [AVG_W-1:0]  smp_q;
  logic              extra_q;
  logic [TIME_W-1:0] tm_q;
  logic [ACC_W-1:0]  acc_q;
  logic              tmr_exp;

  // Bus request, acceptance and address decode
  wire        req      = avs_read_i | avs_write_i;
  wire        wr_acc   = avs_write_i & ~wait_q;
  wire        sel_cfg2 = avs_address_i == `OFS_CONFIG2;
  wire        sel_cfg3 = avs_address_i == `OFS_CONFIG3;
  wire        sel_ctrl = avs_address_i == `OFS_CONTROL;
  wire        sel_sts  = avs_address_i == `OFS_STATUS;
  wire        sel_mask = avs_address_i == `OFS_IRQ_MASK;
  wire        sel_res  = avs_address_i == `OFS_RESULT;
  wire [31:0] be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                          {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wbits    = avs_writedata_i & be_mask;

  // Read data selection; unmapped offsets read as zero
  always_comb begin
    rmux = 32'h0;
    if (sel_cfg2) begin
      rmux = cfg2_q;
    end else if (sel_cfg3) begin
      rmux = cfg3_q;
    end else if (sel_ctrl) begin
      rmux[`CTRL_RUN_BIT] = run_q;
    end else if (sel_sts) begin
      rmux[1:0] = sts_q;
      rmux[`STAT_BUSY_BIT] = busy_q;
    end else if (sel_mask) begin
      rmux[1:0] = mask_q;
    end else if (sel_res) begin
      rmux = {8'h00, result_q};
    end
  end

  // One wait cycle per transfer; read data caught before acceptance
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (req & wait_q) ? rmux : rdata_q;
    end
  end

  // Live configuration fields
  wire [1:0] bridge_sel  = cfg3_q[`CFG3_BRIDGE_MSB:`CFG3_BRIDGE_LSB];
  wire [1:0] stretch_sel = cfg3_q[`CFG3_STRETCH_MSB:`CFG3_STRETCH_LSB];
  assign cfg_live.stretched = stretch_sel != 2'h0;
  assign cfg_live.single    = cfg2_q[`CFG2_SINGLE_BIT];
  assign cfg_live.cps       = (bridge_sel == `BRIDGE_QUATTRO) ? `CPS_QUATTRO :
                              (bridge_sel == `BRIDGE_FULL)    ? `CPS_FULL
                                                              : `CPS_HALF;
  assign cfg_live.avg       = cfg2_q[`CFG2_AVG_MSB:`CFG2_AVG_LSB];
  assign cfg_live.ivl       = cfg2_q[`CFG2_IVL_MSB:`CFG2_IVL_LSB];

  // Sequencer decode
  wire in_idle   = st_q == strain_pkg::ST_IDLE;
  wire in_disch  = st_q == strain_pkg::ST_DISCH;
  wire in_wait   = st_q == strain_pkg::ST_WAIT;
  wire finish    = st_q == strain_pkg::ST_FINISH;
  wire start_seq = in_idle & run_q;
  wire tm_sat    = tm_q == TM_MAX;
  wire norm_to   = ~seq_q.stretched & tmr_exp;
  wire disch_end = in_disch & (comp_i | tm_sat | norm_to);
  wire ovf_evt   = in_disch & ~comp_i & (tm_sat | norm_to);
  wire step      = in_wait & tmr_exp;
  wire last_cyc  = cyc_q == 3'(seq_q.cps - 4'h1);
  wire [AVG_W-1:0] avg_last = (seq_q.avg == '0) ? '0 : seq_q.avg - 1'b1;
  wire last_smp  = smp_q == avg_last;
  wire last_meas = extra_q & (xcnt_q == 3'(EXTRA - 1));

  // Timer reload: at discharge start normally, at discharge end stretched
  wire tmr_load  = start_seq | (step & ~last_meas & ~seq_q.stretched) |
                   (disch_end & seq_q.stretched);

  // Interval timer; step of 2 us or 100 us from the frozen mode
  cycle_interval_timer #(
    .PRESC_NORM (PRESC_NORM),
    .PRESC_STR  (PRESC_STR),
    .IVL_W      (IVL_W)
  ) u_timer (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (tmr_load),
    .stretch_i  (seq_q.stretched),
    .interval_i (seq_q.ivl),
    .expired_o  (tmr_exp)
  );

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      strain_pkg::ST_IDLE:   if (run_q) st_d = strain_pkg::ST_DISCH;
      strain_pkg::ST_DISCH:  if (disch_end) st_d = strain_pkg::ST_WAIT;
      strain_pkg::ST_WAIT: begin
        if (step) begin
          st_d = last_meas ? strain_pkg::ST_FINISH : strain_pkg::ST_DISCH;
        end
      end
      strain_pkg::ST_FINISH: st_d = strain_pkg::ST_IDLE;
      default:               st_d = strain_pkg::ST_IDLE;
    endcase
  end

  // Cycle, sample and extra measurement counters
  wire              samp_step = step & ~extra_q;
  wire [2:0]        cyc_d     = start_seq ? 3'h0 :
                                samp_step ? (last_cyc ? 3'h0 : cyc_q + 3'h1)
                                          : cyc_q;
  wire [AVG_W-1:0]  smp_d     = start_seq ? '0 :
                                (samp_step & last_cyc) ?
                                  (last_smp ? '0 : smp_q + 1'b1) : smp_q;
  wire              extra_d   = start_seq ? 1'b0 :
                                (samp_step & last_cyc & last_smp) ? 1'b1
                                                                  : extra_q;
  wire [2:0]        xcnt_d    = start_seq ? 3'h0 :
                                (step & extra_q) ? xcnt_q + 3'h1 : xcnt_q;

  // Discharge time, and signed sum of pair differences over the samples
  wire [TIME_W-1:0] tm_d      = in_disch ? (tm_sat ? tm_q : tm_q + 1'b1) : '0;
  wire [ACC_W-1:0]  tm_ext    = ACC_W'(tm_q);
  wire [ACC_W-1:0]  acc_d     = start_seq ? '0 :
                                (disch_end & ~extra_q) ?
                                  (cyc_q[0] ? acc_q - tm_ext : acc_q + tm_ext)
                                : acc_q;
  wire [23:0]       res_sat   = ($signed(acc_q) > RMAX) ? `RESULT_MAX :
                                ($signed(acc_q) < RMIN) ? `RESULT_MIN
                                                        : acc_q[23:0];

  // Register writes; hardware events win over a software clear
  wire [31:0] cfg2_d = (wr_acc & sel_cfg2) ?
                       ((cfg2_q & ~be_mask) | wbits) & `CFG2_WMASK : cfg2_q;
  wire [31:0] cfg3_d = (wr_acc & sel_cfg3) ?
                       ((cfg3_q & ~be_mask) | wbits) & `CFG3_WMASK : cfg3_q;
  wire [1:0]  mask_d = (wr_acc & sel_mask) ?
                       ((mask_q & ~be_mask[1:0]) | wbits[1:0]) : mask_q;
  wire [1:0]  w1c    = (wr_acc & sel_sts) ? wbits[1:0] : 2'h0;
  wire [1:0]  evt    = {ovf_evt, finish};
  wire [1:0]  sts_d  = (sts_q & ~w1c) | evt;
  wire        run_d  = (wr_acc & sel_ctrl & avs_byteenable_i[0]) ?
                       avs_writedata_i[`CTRL_RUN_BIT] :
                       (finish & seq_q.single) ? 1'b0 : run_q;

  // Software registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg2_q <= `RST_CONFIG2;
      cfg3_q <= `RST_CONFIG3;
      mask_q <= 2'h0;
      sts_q  <= 2'h0;
      run_q  <= 1'b0;
    end else begin
      cfg2_q <= cfg2_d;
      cfg3_q <= cfg3_d;
      mask_q <= mask_d;
      sts_q  <= sts_d;
      run_q  <= run_d;
    end
  end

  // Sequencer state and counters; configuration frozen while busy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q    <= strain_pkg::ST_IDLE;
      seq_q   <= '0;
      cyc_q   <= 3'h0;
      smp_q   <= '0;
      extra_q <= 1'b0;
      xcnt_q  <= 3'h0;
      tm_q    <= '0;
      acc_q   <= '0;
    end else begin
      st_q    <= st_d;
      seq_q   <= in_idle ? cfg_live : seq_q;
      cyc_q   <= cyc_d;
      smp_q   <= smp_d;
      extra_q <= extra_d;
      xcnt_q  <= xcnt_d;
      tm_q    <= tm_d;
      acc_q   <= acc_d;
    end
  end

  // Result register and registered outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q <= 24'h0;
      disch_q  <= 1'b0;
      busy_q   <= 1'b0;
      calib_q  <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      result_q <= finish ? res_sat : result_q;
      disch_q  <= st_d == strain_pkg::ST_DISCH;
      busy_q   <= st_d != strain_pkg::ST_IDLE;
      calib_q  <= extra_d;
      irq_q    <= |(sts_d & mask_d);
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign discharge_o       = disch_q;
  assign port_sel_o        = cyc_q;
  assign calib_o           = calib_q;
  assign busy_o            = busy_q;
  assign irq_o             = irq_q;

  // Helper counters for the checks below
  logic [23:0] gap_q, rest_q;
  logic        gap_ok_q;
  logic [15:0] n_avg_q;
  logic [3:0]  n_x_q;
  wire         rise_w = (st_d == strain_pkg::ST_DISCH) & ~in_disch;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_q    <= 24'h0;
      rest_q   <= 24'h0;
      gap_ok_q <= 1'b0;
      n_avg_q  <= 16'h0;
      n_x_q    <= 4'h0;
    end else begin
      gap_q    <= rise_w ? 24'h1 : gap_q + 24'h1;
      rest_q   <= disch_end ? 24'h1 : rest_q + 24'h1;
      gap_ok_q <= rise_w ? 1'b1 : (ovf_evt | in_idle) ? 1'b0 : gap_ok_q;
      n_avg_q  <= start_seq ? 16'h0 :
                  (disch_end & ~extra_q) ? n_avg_q + 16'h1 : n_avg_q;
      n_x_q    <= start_seq ? 4'h0 :
                  (disch_end & extra_q) ? n_x_q + 4'h1 : n_x_q;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_NORM_SPACING: assert property (
    (rise_w && in_wait && gap_ok_q && !seq_q.stretched) |->
      (int'(gap_q) == ((seq_q.ivl == '0) ? 1 :
                       int'(seq_q.ivl) * int'(PRESC_NORM))))
    else $error("Normal discharge spacing differs from interval");

  AST_STR_REST: assert property (
    (rise_w && in_wait && seq_q.stretched) |->
      (int'(rest_q) == ((seq_q.ivl == '0) ? 1 :
                        int'(seq_q.ivl) * int'(PRESC_STR))))
    else $error("Stretched wait after discharge differs from interval");

  AST_OVF: assert property (
    (in_disch && !comp_i && !seq_q.stretched && tmr_exp) |=>
      (sts_q[`IRQ_OVF_BIT] && in_wait))
    else $error("Overflow not flagged on short cycle time");

  AST_SAMPLES: assert property (
    finish |-> (int'(n_avg_q) == int'(seq_q.cps) *
                ((seq_q.avg == '0) ? 1 : int'(seq_q.avg))))
    else $error("Sample discharge count wrong at sequence end");

  AST_EXTRA: assert property (
    finish |-> (int'(n_x_q) == int'(EXTRA)))
    else $error("Extra measurement count wrong at sequence end");

  AST_RESULT_RANGE: assert property (
    finish |=> ((result_q != 24'h800000) &&
                (($signed(result_q) >= 0) == ($signed($past(acc_q)) >= 0))))
    else $error("Result outside range or sign lost");

  AST_RESULT_HOLD: assert property (
    !finish |=> $stable(result_q))
    else $error("Result changed before sequence end");

  AST_STRETCH_SEL: assert property (
    in_idle |=> (seq_q.stretched ==
      ($past(cfg3_q[`CFG3_STRETCH_MSB:`CFG3_STRETCH_LSB]) != 2'h0)))
    else $error("Stretched mode does not follow spreading select");

  AST_BRIDGE_SEL: assert property (
    in_idle |=> (seq_q.cps ==
      (($past(bridge_sel) == 2'h3) ? 4'h8 :
       ($past(bridge_sel) == 2'h1) ? 4'h4 : 4'h2)))
    else $error("Cycles per sample do not follow bridge select");

  COV_NORM_SEQ:    cover property (finish && !seq_q.stretched);
  COV_STR_SEQ:     cover property (finish && seq_q.stretched);
  COV_OVERFLOW:    cover property (ovf_evt);
  COV_QUATTRO_SEQ: cover property (finish && seq_q.cps == 4'h8);

endmodule : strain_cycle_timing_averaging

// ===== hdl/strain_pkg.sv
package strain_pkg;

  // Interval width shared by the top and the interval timer, averaging width used by the top
  localparam int unsigned IVL_W = 10;
  localparam int unsigned AVG_W = 10;

  // Sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DISCH  = 2'b01,
    ST_WAIT   = 2'b11,
    ST_FINISH = 2'b10
  } seq_state_t;

  // Configuration frozen for one measurement sequence
  typedef struct packed {
    logic             stretched;
    logic             single;
    logic [3:0]       cps;
    logic [AVG_W-1:0] avg;
    logic [IVL_W-1:0] ivl;
  } seq_cfg_t;

endpackage : strain_pkg

// ===== hdl/strain_regs.svh
`ifndef STRAIN_REGS_SVH
`define STRAIN_REGS_SVH

// Register byte offsets on the Avalon-MM slave
`define OFS_CONFIG2          5'h00
`define OFS_CONFIG3          5'h04
`define OFS_CONTROL          5'h08
`define OFS_STATUS           5'h0c
`define OFS_IRQ_MASK         5'h10
`define OFS_RESULT           5'h14

// Configuration register 2 fields
`define CFG2_SINGLE_BIT      2
`define CFG2_IVL_LSB         4
`define CFG2_IVL_MSB         13
`define CFG2_AVG_LSB         16
`define CFG2_AVG_MSB         25
`define CFG2_WMASK           32'h03ff_3ff4

// Configuration register 3 fields
`define CFG3_BRIDGE_LSB      0
`define CFG3_BRIDGE_MSB      1
`define CONVERTER_TRIM_FACTOR_LSB 4
`define CONVERTER_TRIM_FACTOR_MSB 9
`define CFG3_STRETCH_LSB     12
`define CFG3_STRETCH_MSB     13
`define CFG3_WMASK           32'h0000_33f3

// Control, status and mask fields
`define CTRL_RUN_BIT         0
`define IRQ_DONE_BIT         0
`define IRQ_OVF_BIT          1
`define STAT_BUSY_BIT        8

// Reset values
`define RST_CONFIG2          32'h0008_0500
`define RST_CONFIG3          32'h0000_0101

// Bridge codes and discharge cycles per sample
`define BRIDGE_FULL          2'h1
`define BRIDGE_QUATTRO       2'h3
`define CPS_HALF             4'h2
`define CPS_FULL             4'h4
`define CPS_QUATTRO          4'h8

// Timing: clock period and interval steps in ns
`define CLK_PERIOD_NS        25
`define STEP_NORM_NS         2000
`define STEP_STR_NS          100000

// Extra gain compensation and dummy discharges per sequence
`define EXTRA_CYCLES         4

// Result limits
`define RESULT_MAX           24'h7fffff
`define RESULT_MIN           24'h800001

`endif

// ===== test/bridge_model.sv
`timescale 1ns/100ps

// Resistive bridge discharging the load capacitor through the selected gauge
module bridge_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       discharge_i,
  input  wire logic [2:0] port_sel_i,
  input  wire integer     dly_even_i,
  input  wire integer     dly_odd_i,
  output logic            comp_o
);
  int cnt_q;

  // Threshold crossed after the gauge delay; low again while recharging
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 0;
      comp_o <= 1'b0;
    end else if (!discharge_i) begin
      cnt_q  <= 0;
      comp_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 1;
      comp_o <= (cnt_q + 1 >= (port_sel_i[0] ? dly_odd_i : dly_even_i));
    end
  end
endmodule : bridge_model

// ===== test/strain_cycle_timing_averaging_tb.sv
`timescale 1ns/100ps
`include "strain_regs.svh"

module strain_cycle_timing_averaging_tb;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  adr     = 5'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wd      = 32'h0;
  logic [3:0]  be      = 4'hf;
  logic        dis_q   = 1'b0;
  logic [31:0] rdata, q;
  logic        wreq, comp, dis, calib, busy, irq;
  logic [2:0]  psel;
  int          dly_e = 6, dly_o = 3, error_cnt = 0, checks_done = 0;
  int          cyc = 0, rises = 0, cal_rises = 0, fall_at = 0;
  int          gap = 0, lo = 0, last_rise = 0, cps;

  always #12.5 clk_i = ~clk_i;

  strain_cycle_timing_averaging dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .comp_i(comp), .discharge_o(dis),
    .port_sel_o(psel), .calib_o(calib), .busy_o(busy), .irq_o(irq));

  bridge_model u_bridge (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .discharge_i(dis),
    .port_sel_i(psel), .dly_even_i(dly_e), .dly_odd_i(dly_o),
    .comp_o(comp));

  // Discharge monitor: counts starts, spacing, and the run ceiling
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    dis_q <= dis;
    if (dis && !dis_q) begin
      rises <= rises + 1;
      cal_rises <= cal_rises + int'(calib);
      gap <= cyc - last_rise;
      last_rise <= cyc;
      lo <= cyc - fall_at;
    end
    if (!dis && dis_q) fall_at <= cyc;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One Avalon transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task do_reset;
    rst_n_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset

  function logic [31:0] cfg2_f(input logic [9:0] ivl, input logic [9:0] avg);
    return {6'h00, avg, 2'h0, ivl, 4'h4};
  endfunction : cfg2_f

  // Configure, start one sequence and wait for its end
  task run_seq(input logic [31:0] c2, input logic [31:0] c3);
    bus(1'b1, `OFS_CONFIG3, c3);
    bus(1'b1, `OFS_CONFIG2, c2);
    rises = 0;
    cal_rises = 0;
    bus(1'b1, `OFS_CONTROL, 32'h1);
    repeat (3) @(posedge clk_i);
    while (busy !== 1'b0) @(posedge clk_i);
    @(posedge clk_i);
  endtask : run_seq

  task t_reset;
    bus(1'b0, `OFS_CONFIG2, 32'h0);
    check("config2 reset", q, `RST_CONFIG2);
    bus(1'b0, `OFS_CONFIG3, 32'h0);
    check("config3 reset", q, `RST_CONFIG3);
    bus(1'b1, 5'h18, 32'hffff_ffff);
    bus(1'b0, 5'h18, 32'h0);
    check("unmapped read", q, 32'h0);
    check("idle busy", {31'h0, busy}, 32'h0);
  endtask : t_reset

  // Every bridge code, trim set to twice the averaging count
  task t_bridges;
    for (int b = 0; b < 4; b++) begin
      cps = (b == 3) ? 8 : (b == 1) ? 4 : 2;
      run_seq(cfg2_f(10'd1, 10'd2), 32'h40 | b);
      check("discharges", rises, 2 * cps + 4);
      check("extras", cal_rises, 4);
      check("spacing", gap, 80);
      bus(1'b0, `OFS_RESULT, 32'h0);
      check("result", q, 3 * cps);
      bus(1'b0, `OFS_STATUS, 32'h0);
      check("done", q & 32'h3, 32'h1);
      bus(1'b1, `OFS_STATUS, 32'h3);
    end
  endtask : t_bridges

  task t_negative;
    dly_e = 3;
    dly_o = 9;
    run_seq(cfg2_f(10'd3, 10'd4), 32'h80);
    check("neg discharges", rises, 12);
    check("wide spacing", gap, 240);
    bus(1'b0, `OFS_RESULT, 32'h0);
    check("neg result", q, 32'h00ff_ffe8);
  endtask : t_negative

  // Continuous runs restart by themselves until run is cleared
  task t_continuous;
    run_seq(cfg2_f(10'd1, 10'd2) & ~32'h4, 32'h40);
    repeat (2) @(posedge clk_i);
    check("restart", {31'h0, busy}, 32'h1);
    bus(1'b1, `OFS_CONTROL, 32'h0);
    while (busy !== 1'b0) @(posedge clk_i);
    @(posedge clk_i);
    check("cont discharges", rises, 16);
  endtask : t_continuous

  // Discharge longer than the cycle time, with interrupt masking
  task t_overflow;
    dly_e = 120;
    dly_o = 120;
    bus(1'b1, `OFS_IRQ_MASK, 32'h2);
    run_seq(cfg2_f(10'd1, 10'd2), 32'h40);
    bus(1'b0, `OFS_STATUS, 32'h0);
    check("overflow", q & 32'h3, 32'h3);
    check("irq ovf", {31'h0, irq}, 32'h1);
    bus(1'b1, `OFS_STATUS, 32'h2);
    repeat (2) @(posedge clk_i);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    check("irq done", {31'h0, irq}, 32'h1);
    bus(1'b1, `OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    check("irq clear", {31'h0, irq}, 32'h0);
  endtask : t_overflow

  // Slow clock wait between discharges, then abort by reset
  task t_stretch;
    dly_e = 6;
    dly_o = 3;
    bus(1'b1, `OFS_CONFIG3, 32'h1040);
    bus(1'b1, `OFS_CONFIG2, cfg2_f(10'd1, 10'd2));
    rises = 0;
    bus(1'b1, `OFS_CONTROL, 32'h1);
    while (rises < 2) @(posedge clk_i);
    @(posedge clk_i);
    check("stretch wait", lo, 32'd4000);
    do_reset();
    check("reset busy", {31'h0, busy}, 32'h0);
    bus(1'b0, `OFS_STATUS, 32'h0);
    check("reset status", q, 32'h0);
  endtask : t_stretch

  task conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  initial begin
    do_reset();
    t_reset();
    t_bridges();
    t_negative();
    t_continuous();
    t_overflow();
    t_stretch();
    conclude();
  end
endmodule : strain_cycle_timing_averaging_tb
